// File: pecr_pkg.sv
// package: offsets, fields and reset values of the extended capability registers
// Summary of operation
// - capture header words 2..4 of first uncorrectable error; read-only, sticky, reset zero
// - serial capability header identifier bits 15:0 read 0x3
// - both capability headers report version 0x1 in bits 19:16
// - serial header next pointer bits 31:20 lock-writable, resets zero
// - serial number low word at 0x184, lock-writable, sticky, resets zero
// - serial number high word at 0x188, lock-writable, sticky, resets zero
// - channel capability header identifier bits 15:0 read 0x2
// - channel header next pointer bits 31:20 lock-writable, resets zero
// - extended channel count bits 2:0 reads zero
// - low-priority channel count bits 6:4 reads zero
// - arbitration time reference bits 9:8 reads zero
// - arbitration entry size bits 11:10 reads 0x2 upstream, 0x0 downstream
// - entry size codes: 0 one-bit, 1 two-bit, 2 four-bit, 3 eight-bit
package pecr_pkg;
  localparam logic [11:0] PECR_OFF_HDR2 = 12'h120;
  localparam logic [11:0] PECR_OFF_HDR3 = 12'h124;
  localparam logic [11:0] PECR_OFF_HDR4 = 12'h128;
  localparam logic [11:0] PECR_OFF_SNCAP = 12'h180;
  localparam logic [11:0] PECR_OFF_SNLO = 12'h184;
  localparam logic [11:0] PECR_OFF_SNHI = 12'h188;
  localparam logic [11:0] PECR_OFF_VCCAP = 12'h200;
  localparam logic [11:0] PECR_OFF_PVC1 = 12'h204;
  localparam logic [15:0] PECR_SN_CAP_ID = 16'h0003;
  localparam logic [15:0] PECR_VC_CAP_ID = 16'h0002;
  localparam logic [3:0] PECR_CAP_VER = 4'h1;
  localparam logic [11:0] PECR_NXT_RST = 12'h000;
  localparam logic [31:0] PECR_WORD_RST = 32'h00000000;
  localparam int PECR_ID_LSB = 0;
  localparam int PECR_VER_LSB = 16;
  localparam int PECR_NXT_LSB = 20;
  localparam int PECR_EVC_LSB = 0;
  localparam int PECR_LPEVC_LSB = 4;
  localparam int PECR_TREF_LSB = 8;
  localparam int PECR_ESIZE_LSB = 10;
  localparam logic [2:0] PECR_EVC_CNT = 3'h0;
  localparam logic [2:0] PECR_LPEVC_CNT = 3'h0;
  localparam logic [1:0] PECR_TREF = 2'h0;
  typedef enum logic [1:0]
  {
    PECR_ESZ_1BIT = 2'h0,
    PECR_ESZ_2BIT = 2'h1,
    PECR_ESZ_4BIT = 2'h2,
    PECR_ESZ_8BIT = 2'h3
  } pecr_esize_t;
  localparam pecr_esize_t PECR_ESIZE_UP = PECR_ESZ_4BIT;
  localparam pecr_esize_t PECR_ESIZE_DOWN = PECR_ESZ_1BIT;
endpackage

// File: pecr_log_if.sv
// interface: error header capture strobe and words into the sticky log
`timescale 1ns/1ns
interface pecr_log_if;
  logic capture;
  logic [31:0] word2;
  logic [31:0] word3;
  logic [31:0] word4;
  logic [95:0] held;
  modport src (output capture, output word2, output word3, output word4, input held);
  modport log (input capture, input word2, input word3, input word4, output held);
endinterface

// File: pecr_hdr_log.sv
// module: sticky capture of header words 2..4 for the first uncorrectable error
`timescale 1ns/1ns
module pecr_hdr_log
(
  input wire logic pclk,
  input wire logic porst_n,
  input wire logic clear_first,
  pecr_log_if.log lg
);
  import pecr_pkg::*;
  typedef struct packed
  {
    logic armed_done;
    logic [95:0] words;
  } pecr_log_st_t;
  pecr_log_st_t s_q;
  pecr_log_st_t s_d;
  always_comb
  begin
    s_d = s_q;
    // only the first error is logged until the first-error state is released
    // a capture in the release cycle wins, so no error slips past the rearm
    if (lg.capture && (!s_q.armed_done || clear_first))
    begin
      s_d.words = {lg.word4, lg.word3, lg.word2};
      s_d.armed_done = 1'b1;
    end
    else if (clear_first)
    begin
      s_d.armed_done = 1'b0;
    end
  end
  // power-on reset only: the log is sticky across ordinary resets
  always_ff @(posedge pclk or negedge porst_n)
  begin
    if (!porst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign lg.held = s_q.words;
  a_first_kept: assert property (@(posedge pclk) disable iff (!porst_n)
    s_q.armed_done && !clear_first |=> $stable(s_q.words))
    else $error("header log changed after first error");
  a_capture_taken: assert property (@(posedge pclk) disable iff (!porst_n)
    lg.capture && (!s_q.armed_done || clear_first)
    |=> s_q.words[31:0] == $past(lg.word2) && s_q.words[95:64] == $past(lg.word4))
    else $error("header words not captured");
endmodule // pecr_hdr_log

// File: pecr_regs.sv
// module: apb slave for error header log, serial number and channel capability registers
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module pecr_regs
#(
  parameter bit UPSTREAM = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic porst_n,
  input wire logic cfg_lock,
  input wire logic err_capture,
  input wire logic [31:0] err_word2,
  input wire logic [31:0] err_word3,
  input wire logic [31:0] err_word4,
  input wire logic err_release,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import pecr_pkg::*;
  typedef struct packed
  {
    logic [11:0] sn_nxt;
    logic [11:0] vc_nxt;
    logic [31:0] sn_lo;
    logic [31:0] sn_hi;
  } pecr_sticky_t;
  typedef struct packed
  {
    logic lock;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pecr_bus_t;
  pecr_sticky_t st_q;
  pecr_sticky_t st_d;
  pecr_bus_t b_q;
  pecr_bus_t b_d;
  pecr_log_if lg ();
  logic lock_s1_q;
  logic acc;
  logic hit;
  logic [31:0] rd;
  logic [31:0] wmask;
  pecr_esize_t esize;
  assign lg.capture = err_capture;
  assign lg.word2 = err_word2;
  assign lg.word3 = err_word3;
  assign lg.word4 = err_word4;
  pecr_hdr_log pecr_hdr_log_inst
  (
    .pclk(pclk),
    .porst_n(porst_n),
    .clear_first(err_release),
    .lg(lg)
  );
  assign esize = UPSTREAM ? PECR_ESIZE_UP : PECR_ESIZE_DOWN;
  assign acc = psel && penable && !b_q.ready;
  always_comb
  begin
    rd = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      PECR_OFF_HDR2: rd = lg.held[31:0];
      PECR_OFF_HDR3: rd = lg.held[63:32];
      PECR_OFF_HDR4: rd = lg.held[95:64];
      PECR_OFF_SNCAP:
      begin
        rd[PECR_ID_LSB +: 16] = PECR_SN_CAP_ID;
        rd[PECR_VER_LSB +: 4] = PECR_CAP_VER;
        rd[PECR_NXT_LSB +: 12] = st_q.sn_nxt;
      end
      PECR_OFF_SNLO: rd = st_q.sn_lo;
      PECR_OFF_SNHI: rd = st_q.sn_hi;
      PECR_OFF_VCCAP:
      begin
        rd[PECR_ID_LSB +: 16] = PECR_VC_CAP_ID;
        rd[PECR_VER_LSB +: 4] = PECR_CAP_VER;
        rd[PECR_NXT_LSB +: 12] = st_q.vc_nxt;
      end
      PECR_OFF_PVC1:
      begin
        rd[PECR_EVC_LSB +: 3] = PECR_EVC_CNT;
        rd[PECR_LPEVC_LSB +: 3] = PECR_LPEVC_CNT;
        rd[PECR_TREF_LSB +: 2] = PECR_TREF;
        rd[PECR_ESIZE_LSB +: 2] = esize;
      end
      default: hit = 1'b0;
    endcase
  end
  always_comb
  begin
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    st_d = st_q;
    b_d = b_q;
    b_d.lock = lock_s1_q;
    b_d.ready = acc;
    b_d.err = acc && !hit;
    if (acc && !pwrite)
    begin
      b_d.rdata = rd;
    end
    // locked writes are dropped without an error, like read-only fields
    if (acc && pwrite && !b_q.lock)
    begin
      case (paddr)
        PECR_OFF_SNCAP:
        begin
          if (pstrb[2])
          begin
            st_d.sn_nxt[3:0] = pwdata[23:20];
          end
          if (pstrb[3])
          begin
            st_d.sn_nxt[11:4] = pwdata[31:24];
          end
        end
        PECR_OFF_VCCAP:
        begin
          if (pstrb[2])
          begin
            st_d.vc_nxt[3:0] = pwdata[23:20];
          end
          if (pstrb[3])
          begin
            st_d.vc_nxt[11:4] = pwdata[31:24];
          end
        end
        PECR_OFF_SNLO: st_d.sn_lo = (st_q.sn_lo & ~wmask) | (pwdata & wmask);
        PECR_OFF_SNHI: st_d.sn_hi = (st_q.sn_hi & ~wmask) | (pwdata & wmask);
        default: st_d = st_q;
      endcase
    end
  end
  // sticky state only clears on power-on reset
  always_ff @(posedge pclk or negedge porst_n)
  begin
    if (!porst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_s1_q <= 1'b1;
      b_q <= '{lock: 1'b1, rdata: 32'h00000000, ready: 1'b0, err: 1'b0};
    end
    else
    begin
      lock_s1_q <= cfg_lock;
      b_q <= b_d;
    end
  end
  assign prdata = b_q.rdata;
  assign pready = b_q.ready;
  assign pslverr = b_q.err;
  a_sn_capability_identifier: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == PECR_OFF_SNCAP |=> prdata[19:0] == 20'h10003)
    else $error("serial header id or version wrong");
  a_vc_capability_identifier: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == PECR_OFF_VCCAP |=> prdata[19:0] == 20'h10002)
    else $error("channel header id or version wrong");
  a_pvc_fields: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == PECR_OFF_PVC1 |=>
    prdata == (UPSTREAM ? 32'h00000800 : 32'h00000000))
    else $error("port channel capability word wrong");
  // power-on reset clears sticky state on purpose, so it is left out here
  a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    b_q.lock |=> $stable(st_q))
    else $error("lock-writable field changed while locked");
  a_lo_write: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && pwrite && !b_q.lock && paddr == PECR_OFF_SNLO && pstrb == 4'hF
    |=> st_q.sn_lo == $past(pwdata))
    else $error("serial low word not written");
  a_hi_write: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && pwrite && !b_q.lock && paddr == PECR_OFF_SNHI && pstrb == 4'hF
    |=> st_q.sn_hi == $past(pwdata))
    else $error("serial high word not written");
  a_nxt_read: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && !pwrite && paddr == PECR_OFF_VCCAP |=> prdata[31:20] == $past(st_q.vc_nxt))
    else $error("channel next pointer read wrong");
  a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_sn_nxt_read: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && !pwrite && paddr == PECR_OFF_SNCAP |=> prdata[31:20] == $past(st_q.sn_nxt))
    else $error("serial next pointer read wrong");
  a_lo_read: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && !pwrite && paddr == PECR_OFF_SNLO |=> prdata == $past(st_q.sn_lo))
    else $error("serial low word read wrong");
  a_hdr_read: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && !pwrite && paddr == PECR_OFF_HDR3 |=> prdata == $past(lg.held[63:32]))
    else $error("header log word read wrong");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !hit |=> pready && pslverr)
    else $error("unmapped access without error response");
  a_ro_write: assert property (@(posedge pclk) disable iff (!presetn || !porst_n)
    acc && pwrite && paddr == PECR_OFF_PVC1 |=> $stable(st_q))
    else $error("read-only write changed state");
endmodule // pecr_regs

// File: test_pecr_regs.sv
// testbench: apb access, lock, error log capture and sticky reset of pecr_regs
`timescale 1ns/1ns
module test_pecr_regs;
  import pecr_pkg::*;
  typedef struct {bit wr; logic [11:0] addr; logic [31:0] val; logic err;} pecr_row_t;
  logic pclk = 1'b0, presetn = 1'b0, porst_n = 1'b0, cfg_lock = 1'b0;
  logic err_capture = 1'b0, err_release = 1'b0;
  logic [31:0] err_word2 = 32'h0, err_word3 = 32'h0, err_word4 = 32'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, prdata_dn;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, er;
  int n_errors = 0;
  int n_tests = 0;
  // reads check val and err, writes use val as data and check err only
  pecr_row_t rows [20] = '{
    '{1'b0, 12'h120, 32'h0, 1'b0},
    '{1'b0, 12'h124, 32'h0, 1'b0},
    '{1'b0, 12'h128, 32'h0, 1'b0},
    '{1'b0, 12'h180, 32'h00010003, 1'b0},
    '{1'b0, 12'h184, 32'h0, 1'b0},
    '{1'b0, 12'h188, 32'h0, 1'b0},
    '{1'b0, 12'h200, 32'h00010002, 1'b0},
    '{1'b0, 12'h204, 32'h00000800, 1'b0},
    '{1'b0, 12'h300, 32'h0, 1'b1},
    '{1'b1, 12'h184, 32'hA5A51234, 1'b0},
    '{1'b1, 12'h188, 32'h0F0F5678, 1'b0},
    '{1'b1, 12'h180, 32'hFFFFFFFF, 1'b0},
    '{1'b1, 12'h200, 32'h12300000, 1'b0},
    '{1'b1, 12'h204, 32'hFFFFFFFF, 1'b0},
    '{1'b1, 12'h300, 32'hFFFFFFFF, 1'b1},
    '{1'b0, 12'h184, 32'hA5A51234, 1'b0},
    '{1'b0, 12'h188, 32'h0F0F5678, 1'b0},
    '{1'b0, 12'h180, 32'hFFF10003, 1'b0},
    '{1'b0, 12'h200, 32'h12310002, 1'b0},
    '{1'b0, 12'h204, 32'h00000800, 1'b0}};
  pecr_regs #(.UPSTREAM(1'b1)) pecr_regs_inst (.pclk(pclk), .presetn(presetn),
    .porst_n(porst_n), .cfg_lock(cfg_lock), .err_capture(err_capture),
    .err_word2(err_word2), .err_word3(err_word3), .err_word4(err_word4),
    .err_release(err_release), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // downstream copy on the same bus shows the other entry-size setting
  pecr_regs #(.UPSTREAM(1'b0)) pecr_regs_dn_inst (.pclk(pclk), .presetn(presetn),
    .porst_n(porst_n), .cfg_lock(cfg_lock), .err_capture(err_capture),
    .err_word2(err_word2), .err_word3(err_word3), .err_word4(err_word4),
    .err_release(err_release), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_dn), .pready(),
    .pslverr());
  always #4 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pready is sampled at the rising edge; the request stands until that edge
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1)
      chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk("rdata", e, rd);
  endtask
  task automatic cap(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
    input bit rel);
    @(posedge pclk);
    err_word2 <= a;
    err_word3 <= b;
    err_word4 <= c;
    err_capture <= 1'b1;
    err_release <= rel;
    @(posedge pclk);
    err_capture <= 1'b0;
    err_release <= 1'b0;
  endtask
  task automatic logchk(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    rdchk(12'h120, a);
    rdchk(12'h124, b);
    rdchk(12'h128, c);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    porst_n <= 1'b1;
    // lock synchroniser needs two edges before unlocked writes act
    repeat (3) @(posedge pclk);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].val, {4{rows[i].wr}});
      if (!rows[i].wr)
        chk("rdata", rows[i].val, rd);
      chk("pslverr", {31'h0, rows[i].err}, {31'h0, er});
    end
    rdchk(12'h204, 32'h00000800);
    chk("rdata_dn", 32'h00000000, prdata_dn);
    apb(1'b1, 12'h184, 32'hFFFFFFFF, 4'h1);
    rdchk(12'h184, 32'hA5A512FF);
    apb(1'b1, 12'h180, 32'h0, 4'h8);
    rdchk(12'h180, 32'h00F10003);
    cfg_lock <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b1, 12'h188, 32'h0, 4'hF);
    apb(1'b1, 12'h200, 32'h0, 4'hF);
    rdchk(12'h188, 32'h0F0F5678);
    rdchk(12'h200, 32'h12310002);
    cap(32'h11111111, 32'h22222222, 32'h33333333, 1'b0);
    cap(32'h44444444, 32'h55555555, 32'h66666666, 1'b0);
    logchk(32'h11111111, 32'h22222222, 32'h33333333);
    @(posedge pclk);
    err_release <= 1'b1;
    @(posedge pclk);
    err_release <= 1'b0;
    cap(32'h44444444, 32'h55555555, 32'h66666666, 1'b0);
    logchk(32'h44444444, 32'h55555555, 32'h66666666);
    // release and capture in one cycle: the capture must win
    cap(32'h77777777, 32'h88888888, 32'h99999999, 1'b1);
    logchk(32'h77777777, 32'h88888888, 32'h99999999);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h184, 32'hA5A512FF);
    rdchk(12'h120, 32'h77777777);
    porst_n <= 1'b0;
    repeat (5) @(posedge pclk);
    porst_n <= 1'b1;
    rdchk(12'h188, 32'h0);
    rdchk(12'h124, 32'h0);
    rdchk(12'h180, 32'h00010003);
    rdchk(12'h200, 32'h00010002);
    give_verdict();
  end
  initial
  begin
    repeat (4000) @(posedge pclk);
    n_errors++;
    $display("[ERR] run length expected under 4000 cycles seen more");
    give_verdict();
  end
endmodule // test_pecr_regs
